// [rtl/ocp_pkg.sv]
/*
 * Shared constants, types and reset values for the overcurrent protection control.
 * Assumes a single 20 MHz system clock; the analog comparators and switches live outside.
 */
package ocp_pkg;

  // ==========================================================================
  // Clock and timing.
  localparam int CLK_HZ        = 20_000_000;
  localparam int CYC_PER_US    = CLK_HZ / 1_000_000;
  localparam int DG_US_0       = 10;
  localparam int DG_US_1       = 20;
  localparam int DG_US_2       = 50;
  localparam int DG_US_3       = 100;
  localparam int DG_CYC_0      = DG_US_0 * CYC_PER_US;
  localparam int DG_CYC_1      = DG_US_1 * CYC_PER_US;
  localparam int DG_CYC_2      = DG_US_2 * CYC_PER_US;
  localparam int DG_CYC_3      = DG_US_3 * CYC_PER_US;
  localparam int REACT_US_0    = 25;
  localparam int REACT_US_1    = 50;
  localparam int REACT_US_2    = 100;
  localparam int REACT_US_3    = 200;
  localparam int REACT_CYC_0   = REACT_US_0 * CYC_PER_US;
  localparam int REACT_CYC_1   = REACT_US_1 * CYC_PER_US;
  localparam int REACT_CYC_2   = REACT_US_2 * CYC_PER_US;
  localparam int REACT_CYC_3   = REACT_US_3 * CYC_PER_US;
  localparam int LIM_MS_1      = 1;
  localparam int LIM_MS_2      = 2;
  localparam int LIM_MS_3      = 5;
  localparam int LIM_MS_4      = 10;
  localparam int LIM_CYC_1     = LIM_MS_1 * 1000 * CYC_PER_US;
  localparam int LIM_CYC_2     = LIM_MS_2 * 1000 * CYC_PER_US;
  localparam int LIM_CYC_3     = LIM_MS_3 * 1000 * CYC_PER_US;
  localparam int LIM_CYC_4     = LIM_MS_4 * 1000 * CYC_PER_US;
  localparam int SC_REACT_NS   = 5000;
  localparam int SC_CYC        = SC_REACT_NS * CYC_PER_US / 1000;
  localparam int CIN_STEP_US   = 50;
  localparam int CIN_STEP_CYC  = CIN_STEP_US * CYC_PER_US;
  localparam int CIN_MAX_US    = 10000;
  localparam int CIN_MAX_STEPS = CIN_MAX_US / CIN_STEP_US;
  localparam int TMR_W         = 18;

  // ==========================================================================
  // Field codes and reset values.
  localparam logic [7:0] ILIM_RST      = 8'h19;
  localparam logic [1:0] THR_RST       = 2'h3;
  localparam logic [1:0] DG_RST        = 2'h0;
  localparam logic [1:0] REACT_RST     = 2'h0;
  localparam logic [2:0] LIM_INFINITE  = 3'h0;
  localparam logic [2:0] LIM_RST       = 3'h0;
  localparam logic [7:0] CIN_STEPS_RST = 8'hc8;

  // ==========================================================================
  // Types.
  typedef enum logic [2:0] {
    ST_VOLT   = 3'b000,
    ST_DEGL   = 3'b001,
    ST_REACT  = 3'b010,
    ST_SETTLE = 3'b011,
    ST_HOLD   = 3'b100,
    ST_HIZ    = 3'b101
  } ocp_state_t;

  typedef enum logic [1:0] {
    STAGE_VOLT = 2'b00,
    STAGE_ILIM = 2'b01,
    STAGE_HIZ  = 2'b10
  } ocp_stage_t;

  typedef struct packed {
    logic       cin_mode;
    logic       resp_limit;
    logic [1:0] thr_sel;
    logic [1:0] dg_sel;
    logic [1:0] react_sel;
    logic [2:0] lim_sel;
    logic [7:0] cin_steps;
  } ocp_cfg_t;

  typedef struct packed {
    logic cin_trip;
    logic short_trip;
    logic lim_fail;
    logic ovl_hiz;
  } ocp_stat_t;

  localparam ocp_cfg_t CFG_RST = '{cin_mode: 1'b0, resp_limit: 1'b0, thr_sel: THR_RST, dg_sel: DG_RST,
                                   react_sel: REACT_RST, lim_sel: LIM_RST, cin_steps: CIN_STEPS_RST};

endpackage

// [rtl/ocp_timer.sv]
/*
 * One-shot down counter used for the deglitch, reaction and limiter periods.
 * Assumes a synchronous start strobe from logic on the same clock.
 */
`timescale 1ns/1ns
`default_nettype none
module ocp_timer #(
  parameter int W = 18
) (
  // Clock and reset.
  input  wire logic         clock,
  input  wire logic         rst_n,
  // Control.
  input  wire logic         start,
  input  wire logic         cancel,
  input  wire logic [W-1:0] len,
  // Status.
  output wire logic         busy,
  output wire logic         done
);

  logic [W-1:0] cnt_q;
  logic         armed_q;

  // ==========================================================================
  // Counter. A length of N gives done exactly N cycles after start.
  assign busy = armed_q;
  assign done = armed_q && (cnt_q == '0);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q   <= '0;
      armed_q <= 1'b0;
    end else if (start) begin
      cnt_q   <= len - W'(1);
      armed_q <= 1'b1;
    end else if (cancel || done) begin
      armed_q <= 1'b0;
    end else if (armed_q) begin
      cnt_q <= cnt_q - W'(1);
    end
  end

endmodule
`default_nettype wire

// [rtl/ocp_ctrl.sv]
/*
 * Overcurrent protection control for the analog output stage and current input switch.
 * Assumes comparator levels arrive asynchronously and configuration strobes are on clock.
 */
// Functional notes
// - Overload must persist through a 10/20/50/100 us deglitch time before action.
// - Overload threshold select among 5, 10, 20 or 25 mA is provided.
// - Surviving overload triggers the configured response: high impedance or limiter.
// - Reaction time selects 25/50/100/200 us, 25 us after reset.
// - Overload still present after reaction time enters current limit.
// - Limit value sits in a shadow register, default 25 mA, used on entry; the code drives ilim straight from ilim_q, so writes apply at once.
// - Overload after limiter settle time forces high impedance, alarm and status.
// - Settled limiter holds for infinite or 1/2/5/10 ms.
// - Finite limiter period end returns the stage to voltage output.
// - Current-input overcurrent lasting 50 us to 10 ms opens the input switch.
// - Short circuit beyond 5 us reaction forces high impedance; the code does so only with cin_mode clear.
`timescale 1ns/1ns
`default_nettype none
module ocp_ctrl #(
  parameter int LIM_CYC_1 = ocp_pkg::LIM_CYC_1,
  parameter int LIM_CYC_2 = ocp_pkg::LIM_CYC_2,
  parameter int LIM_CYC_3 = ocp_pkg::LIM_CYC_3,
  parameter int LIM_CYC_4 = ocp_pkg::LIM_CYC_4
) (
  // Clock and reset.
  input  wire logic               clock,
  input  wire logic               rstn,
  // Analog comparators.
  input  wire logic               ovl_cmp,
  input  wire logic               short_cmp,
  input  wire logic               cin_ovc_cmp,
  // Configuration and software strobes.
  input  wire logic               cfg_wr,
  input  wire ocp_pkg::ocp_cfg_t  cfg_in,
  input  wire logic               ilim_wr,
  input  wire logic [7:0]         ilim_in,
  input  wire logic               alarm_ack,
  input  wire logic               rearm,
  // Output stage control and status.
  output var  ocp_pkg::ocp_stage_t stage,
  output logic [1:0]              ovl_thr,
  output logic [7:0]              ilim,
  output logic                    current_input_switch_open,
  output logic                    alarm,
  output var  ocp_pkg::ocp_stat_t status
);

  // ==========================================================================
  // Reset release and input synchronisers.
  logic rst_meta_q;
  logic rst_n;
  logic [2:0] in_meta_q;
  logic [2:0] in_sync_q;

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      in_meta_q <= 3'h0;
      in_sync_q <= 3'h0;
    end else begin
      in_meta_q <= {cin_ovc_cmp, short_cmp, ovl_cmp};
      in_sync_q <= in_meta_q;
    end
  end

  wire ovl_s = in_sync_q[0];
  wire sc_s  = in_sync_q[1];
  wire cin_s = in_sync_q[2];

  // ==========================================================================
  // Configuration and limit shadow.
  ocp_pkg::ocp_cfg_t cfg_q;
  logic [7:0]        ilim_q;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q  <= ocp_pkg::CFG_RST;
      ilim_q <= ocp_pkg::ILIM_RST;
    end else begin
      if (cfg_wr) cfg_q <= cfg_in;
      if (ilim_wr) ilim_q <= ilim_in;
    end
  end

  // ==========================================================================
  // Period lookups.
  localparam int TW = ocp_pkg::TMR_W;

  function automatic logic [TW-1:0] dg_len(input logic [1:0] sel);
    case (sel)
      2'h0:    dg_len = TW'(ocp_pkg::DG_CYC_0);
      2'h1:    dg_len = TW'(ocp_pkg::DG_CYC_1);
      2'h2:    dg_len = TW'(ocp_pkg::DG_CYC_2);
      default: dg_len = TW'(ocp_pkg::DG_CYC_3);
    endcase
  endfunction

  function automatic logic [TW-1:0] react_len(input logic [1:0] sel);
    case (sel)
      2'h0:    react_len = TW'(ocp_pkg::REACT_CYC_0);
      2'h1:    react_len = TW'(ocp_pkg::REACT_CYC_1);
      2'h2:    react_len = TW'(ocp_pkg::REACT_CYC_2);
      default: react_len = TW'(ocp_pkg::REACT_CYC_3);
    endcase
  endfunction

  function automatic logic [TW-1:0] lim_len(input logic [2:0] sel);
    case (sel)
      3'h1:    lim_len = TW'(LIM_CYC_1);
      3'h2:    lim_len = TW'(LIM_CYC_2);
      3'h3:    lim_len = TW'(LIM_CYC_3);
      default: lim_len = TW'(LIM_CYC_4);
    endcase
  endfunction

  // ==========================================================================
  // Short-circuit reaction counter.
  // The coarse analog limiter clamps the current meanwhile; this only decides when to give up.
  logic [7:0] sc_cnt_q;
  wire        sc_trip = (sc_cnt_q == 8'(ocp_pkg::SC_CYC - 1)) && sc_s;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) sc_cnt_q <= 8'h00;
    else if (!sc_s || sc_trip) sc_cnt_q <= 8'h00;
    else sc_cnt_q <= sc_cnt_q + 8'h01;
  end

  // ==========================================================================
  // Voltage-output protection sequence.
  ocp_pkg::ocp_state_t  state_q;
  ocp_pkg::ocp_state_t  state_d;
  ocp_pkg::ocp_stage_t  stage_q;
  logic                 tmr_start;
  logic [TW-1:0]        tmr_len;
  logic                 tmr_done;
  logic                 set_ovl_hiz;
  logic                 set_lim_fail;
  logic                 alarm_q;

  always_comb begin
    state_d      = state_q;
    tmr_start    = 1'b0;
    tmr_len      = dg_len(cfg_q.dg_sel);
    set_ovl_hiz  = 1'b0;
    set_lim_fail = 1'b0;
    case (state_q)
      ocp_pkg::ST_VOLT: begin
        if (ovl_s && !cfg_q.cin_mode) begin
          state_d   = ocp_pkg::ST_DEGL;
          tmr_start = 1'b1;
        end
      end
      ocp_pkg::ST_DEGL: begin
        if (!ovl_s) state_d = ocp_pkg::ST_VOLT;
        else if (tmr_done && !cfg_q.resp_limit) begin
          state_d     = ocp_pkg::ST_HIZ;
          set_ovl_hiz = 1'b1;
        end else if (tmr_done) begin
          state_d   = ocp_pkg::ST_REACT;
          tmr_start = 1'b1;
          tmr_len   = react_len(cfg_q.react_sel);
        end
      end
      ocp_pkg::ST_REACT: begin
        if (tmr_done && !ovl_s) state_d = ocp_pkg::ST_VOLT;
        else if (tmr_done) begin
          state_d   = ocp_pkg::ST_SETTLE;
          tmr_start = 1'b1;
          tmr_len   = react_len(cfg_q.react_sel);
        end
      end
      ocp_pkg::ST_SETTLE: begin
        if (tmr_done && ovl_s) begin
          state_d      = ocp_pkg::ST_HIZ;
          set_lim_fail = 1'b1;
        end else if (tmr_done) begin
          state_d   = ocp_pkg::ST_HOLD;
          tmr_start = (cfg_q.lim_sel != ocp_pkg::LIM_INFINITE);
          tmr_len   = lim_len(cfg_q.lim_sel);
        end
      end
      ocp_pkg::ST_HOLD: begin
        if (tmr_done) state_d = ocp_pkg::ST_VOLT;
      end
      ocp_pkg::ST_HIZ: begin
        if (rearm && !alarm_q) state_d = ocp_pkg::ST_VOLT;
      end
      default: state_d = ocp_pkg::ST_HIZ;
    endcase
    if (sc_trip && !cfg_q.cin_mode) begin
      state_d   = ocp_pkg::ST_HIZ;
      tmr_start = 1'b0;
    end
  end

  wire tmr_cancel = (state_d == ocp_pkg::ST_VOLT) || (state_d == ocp_pkg::ST_HIZ);

  ocp_timer #(.W(TW)) u_timer (
    .clock  (clock),
    .rst_n  (rst_n),
    .start  (tmr_start),
    .cancel (tmr_cancel),
    .len    (tmr_len),
    .busy   (),
    .done   (tmr_done)
  );

  // High impedance is the safe default, so it is also the stage shown during reset.
  wire ocp_pkg::ocp_stage_t stage_d =
    (state_d == ocp_pkg::ST_HIZ) ? ocp_pkg::STAGE_HIZ :
    ((state_d == ocp_pkg::ST_SETTLE) || (state_d == ocp_pkg::ST_HOLD)) ? ocp_pkg::STAGE_ILIM :
    ocp_pkg::STAGE_VOLT;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= ocp_pkg::ST_VOLT;
      stage_q <= ocp_pkg::STAGE_HIZ;
    end else begin
      state_q <= state_d;
      stage_q <= stage_d;
    end
  end

  // ==========================================================================
  // Current-input overcurrent timing in 50 us steps.
  logic [15:0] cin_div_q;
  logic [7:0]  cin_steps_q;
  logic        current_input_switch_q;
  wire  [7:0]  cin_lim = (cfg_q.cin_steps == 8'h00) ? 8'h01 :
                         (cfg_q.cin_steps > 8'(ocp_pkg::CIN_MAX_STEPS)) ? 8'(ocp_pkg::CIN_MAX_STEPS) :
                         cfg_q.cin_steps;
  wire         cin_tick = cin_s && (cin_div_q == 16'(ocp_pkg::CIN_STEP_CYC - 1));
  wire         cin_trip = cfg_q.cin_mode && cin_tick && (cin_steps_q == cin_lim - 8'h01);

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cin_div_q   <= 16'h0000;
      cin_steps_q <= 8'h00;
    end else if (!cin_s || !cfg_q.cin_mode || current_input_switch_q) begin
      cin_div_q   <= 16'h0000;
      cin_steps_q <= 8'h00;
    end else if (cin_tick) begin
      cin_div_q   <= 16'h0000;
      cin_steps_q <= cin_steps_q + 8'h01;
    end else begin
      cin_div_q <= cin_div_q + 16'h0001;
    end
  end

  // ==========================================================================
  // Sticky status and alarm; a new event beats a simultaneous acknowledge.
  ocp_pkg::ocp_stat_t stat_q;
  wire ocp_pkg::ocp_stat_t stat_set = '{cin_trip: cin_trip, short_trip: sc_trip && !cfg_q.cin_mode,
                                        lim_fail: set_lim_fail, ovl_hiz: set_ovl_hiz};
  wire ocp_pkg::ocp_stat_t stat_d = (alarm_ack ? '0 : stat_q) | stat_set;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      stat_q  <= '0;
      alarm_q <= 1'b0;
      current_input_switch_q  <= 1'b0;
    end else begin
      stat_q  <= stat_d;
      alarm_q <= |stat_d;
      current_input_switch_q  <= cin_trip || (current_input_switch_q && !alarm_ack);
    end
  end

  assign stage                     = stage_q;
  assign ovl_thr                   = cfg_q.thr_sel;
  assign ilim                      = ilim_q;
  assign current_input_switch_open = current_input_switch_q;
  assign alarm                     = alarm_q;
  assign status                    = stat_q;

  // ==========================================================================
  // Assertions.
  property p_deglitch_drop;
    @(posedge clock) disable iff (!rst_n)
      (state_q == ocp_pkg::ST_DEGL) && !ovl_s && !sc_trip |=> (state_q == ocp_pkg::ST_VOLT);
  endproperty
  a_deglitch_drop: assert property (p_deglitch_drop) else $error("Short overload was not ignored.");

  property p_resp_hiz;
    @(posedge clock) disable iff (!rst_n)
      (state_q == ocp_pkg::ST_DEGL) && ovl_s && tmr_done && !cfg_q.resp_limit
      |=> (stage_q == ocp_pkg::STAGE_HIZ) && alarm_q;
  endproperty
  a_resp_hiz: assert property (p_resp_hiz) else $error("Deglitched overload did not go high impedance.");

  property p_react_len;
    @(posedge clock) disable iff (!rst_n)
      (state_q == ocp_pkg::ST_DEGL) ##1 (state_q == ocp_pkg::ST_REACT) && (cfg_q.react_sel == 2'h0) && !sc_s
      |-> (state_q == ocp_pkg::ST_REACT) [*8];
  endproperty
  a_react_len: assert property (p_react_len) else $error("Reaction wait ended too early.");

  property p_enter_limit;
    @(posedge clock) disable iff (!rst_n)
      (state_q == ocp_pkg::ST_REACT) && tmr_done && ovl_s && !sc_trip |=> (stage_q == ocp_pkg::STAGE_ILIM);
  endproperty
  a_enter_limit: assert property (p_enter_limit) else $error("Limiter was not entered.");

  property p_shadow;
    @(posedge clock) disable iff (!rst_n)
      ilim_wr |=> (ilim == $past(ilim_in));
  endproperty
  a_shadow: assert property (p_shadow) else $error("Limit shadow did not take the write.");

  property p_lim_fail;
    @(posedge clock) disable iff (!rst_n)
      (state_q == ocp_pkg::ST_SETTLE) && tmr_done && ovl_s |=> stat_q.lim_fail && alarm_q && (stage_q == ocp_pkg::STAGE_HIZ);
  endproperty
  a_lim_fail: assert property (p_lim_fail) else $error("Failed limiter did not raise the alarm.");

  property p_infinite;
    @(posedge clock) disable iff (!rst_n)
      (state_q == ocp_pkg::ST_HOLD) && (cfg_q.lim_sel == ocp_pkg::LIM_INFINITE) && !sc_trip && !tmr_done
      |=> (state_q == ocp_pkg::ST_HOLD);
  endproperty
  a_infinite: assert property (p_infinite) else $error("Infinite limiter period ended.");

  property p_return_volt;
    @(posedge clock) disable iff (!rst_n)
      (state_q == ocp_pkg::ST_HOLD) && tmr_done && !sc_trip |=> (stage_q == ocp_pkg::STAGE_VOLT);
  endproperty
  a_return_volt: assert property (p_return_volt) else $error("Stage did not return to voltage output.");

  property p_cin_open;
    @(posedge clock) disable iff (!rst_n)
      cin_trip |=> current_input_switch_open && status.cin_trip;
  endproperty
  a_cin_open: assert property (p_cin_open) else $error("Input switch did not open.");

  property p_short;
    @(posedge clock) disable iff (!rst_n)
      !cfg_q.cin_mode && sc_s [*8] ##0 $stable(cfg_q) |-> ##[0:100] ((stage_q == ocp_pkg::STAGE_HIZ) || !sc_s);
  endproperty
  a_short: assert property (p_short) else $error("Short circuit not cut off in time.");

  property p_restart;
    @(posedge clock) disable iff (!rst_n)
      (state_q == ocp_pkg::ST_VOLT) && ovl_s && !cfg_q.cin_mode && !sc_trip |=> (state_q == ocp_pkg::ST_DEGL);
  endproperty
  a_restart: assert property (p_restart) else $error("Overload did not restart the deglitch.");

  property p_sticky;
    @(posedge clock) disable iff (!rst_n)
      alarm_q && !alarm_ack |=> alarm_q && (state_q != ocp_pkg::ST_VOLT || !$past(state_q == ocp_pkg::ST_HIZ));
  endproperty
  a_sticky: assert property (p_sticky) else $error("Alarm or high impedance dropped without acknowledge.");

endmodule
`default_nettype wire

// [tb/ocp_load_model.sv]
/*
 * Load model on the output terminal, seen only through the three comparators.
 * Assumes the bench picks the load behaviour and that the design package is compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module ocp_load_model (
  // Clock.
  input  wire logic                clock,
  // Design outputs seen by the load.
  input  wire ocp_pkg::ocp_stage_t stage,
  input  wire logic                sw_open,
  // Load behaviour chosen by the bench.
  input  wire logic                ovl_req,
  input  wire logic                stiff,
  input  wire logic                short_req,
  input  wire logic                cin_req,
  // Comparator levels.
  output logic                     ovl_cmp,
  output logic                     short_cmp,
  output logic                     cin_ovc_cmp
);
  // ==========================================================================
  // Comparators.
  initial begin
    ovl_cmp = 1'b0;
    short_cmp = 1'b0;
    cin_ovc_cmp = 1'b0;
  end

  // A high-Z stage carries no current; a soft load settles under the limit, a stiff one does not.
  always @(posedge clock) begin
    ovl_cmp <= ovl_req && (stage == ocp_pkg::STAGE_VOLT || (stage == ocp_pkg::STAGE_ILIM && stiff));
    short_cmp <= short_req && stage != ocp_pkg::STAGE_HIZ;
    cin_ovc_cmp <= cin_req && !sw_open;
  end
endmodule
`default_nettype wire

// [tb/ocp_ctrl_tb_top.sv]
/*
 * Self-checking bench for the overcurrent protection control with a load model.
 * Assumes the package, the timer and the control block are compiled first.
 */
`timescale 1ns/1ns
`default_nettype none
module ocp_ctrl_tb_top;
  // ==========================================================================
  // Signals.
  localparam logic [7:0] S_VOLT = 8'(ocp_pkg::STAGE_VOLT);
  localparam logic [7:0] S_ILIM = 8'(ocp_pkg::STAGE_ILIM);
  localparam logic [7:0] S_HIZ  = 8'(ocp_pkg::STAGE_HIZ);
  localparam int         DG0    = ocp_pkg::DG_CYC_0;
  logic                clock     = 1'b0;
  logic                rstn      = 1'b0;
  logic                cfg_wr    = 1'b0;
  logic                ilim_wr   = 1'b0;
  logic                alarm_ack = 1'b0;
  logic                rearm     = 1'b0;
  logic                ovl_req   = 1'b0;
  logic                stiff     = 1'b0;
  logic                short_req = 1'b0;
  logic                cin_req   = 1'b0;
  logic [7:0]          ilim_in   = 8'h00;
  ocp_pkg::ocp_cfg_t   cfg_in    = ocp_pkg::CFG_RST;
  ocp_pkg::ocp_cfg_t   c;
  logic                ovl_cmp, short_cmp, cin_ovc_cmp, sw_open, alarm;
  ocp_pkg::ocp_stage_t stage;
  ocp_pkg::ocp_stat_t  status;
  logic [1:0]          ovl_thr;
  logic [7:0]          ilim;
  int                  n_fail = 0, samples_checked = 0, cyc = 0;

  always #25 clock = ~clock;

  // Short limiter periods keep the run brief; expectations use the same values.
  ocp_ctrl #(.LIM_CYC_1(50), .LIM_CYC_2(100), .LIM_CYC_3(150), .LIM_CYC_4(200)) dut (
    .clock(clock), .rstn(rstn), .ovl_cmp(ovl_cmp), .short_cmp(short_cmp), .cin_ovc_cmp(cin_ovc_cmp),
    .cfg_wr(cfg_wr), .cfg_in(cfg_in), .ilim_wr(ilim_wr), .ilim_in(ilim_in), .alarm_ack(alarm_ack),
    .rearm(rearm), .stage(stage), .ovl_thr(ovl_thr), .ilim(ilim), .current_input_switch_open(sw_open),
    .alarm(alarm), .status(status));

  ocp_load_model load (.clock(clock), .stage(stage), .sw_open(sw_open), .ovl_req(ovl_req), .stiff(stiff),
    .short_req(short_req), .cin_req(cin_req), .ovl_cmp(ovl_cmp), .short_cmp(short_cmp),
    .cin_ovc_cmp(cin_ovc_cmp));

  // ==========================================================================
  // Shared tasks.
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, e, g);
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic put_cfg(input ocp_pkg::ocp_cfg_t v);
    cfg_in = v;
    cfg_wr = 1'b1;
    cyc_n(1);
    cfg_wr = 1'b0;
    cyc_n(1);
  endtask

  // Waits for the stage (sel 0) or the switch (sel 1) and checks the cycles taken.
  task automatic wait_ev(input bit sel, input logic [7:0] e, input int lo, input int hi);
    int n;
    n = 0;
    while ((sel ? {7'h00, sw_open} : 8'(stage)) !== e && n <= hi) begin
      cyc_n(1);
      n++;
    end
    chk(sel ? "switch" : "stage", e, sel ? {7'h00, sw_open} : 8'(stage));
    chk("elapsed", 8'h01, 8'(n >= lo && n <= hi));
  endtask

  task automatic recover(input logic [7:0] st, input logic [7:0] stg);
    ovl_req = 1'b0;
    short_req = 1'b0;
    cin_req = 1'b0;
    stiff = 1'b0;
    chk("status", st, 8'(status));
    chk("alarm", 8'h01, 8'(alarm));
    rearm = 1'b1;
    cyc_n(1);
    rearm = 1'b0;
    cyc_n(3);
    chk("stage", stg, 8'(stage));
    alarm_ack = 1'b1;
    cyc_n(1);
    alarm_ack = 1'b0;
    cyc_n(2);
    chk("status", 8'h00, 8'(status));
    chk("alarm", 8'h00, 8'(alarm));
    chk("switch", 8'h00, 8'(sw_open));
    rearm = 1'b1;
    cyc_n(1);
    rearm = 1'b0;
    cyc_n(2);
    chk("stage", S_VOLT, 8'(stage));
  endtask

  // ==========================================================================
  // Scenarios.
  task automatic t_reset_thr();
    chk("stage", S_VOLT, 8'(stage));
    chk("ilim", 8'h19, ilim);
    chk("status", 8'h00, 8'(status));
    for (int i = 0; i < 4; i++) begin
      c = ocp_pkg::CFG_RST;
      c.thr_sel = 2'(i);
      put_cfg(c);
      chk("ovl_thr", 8'(i), 8'(ovl_thr));
    end
  endtask

  task automatic t_glitch_hiz();
    c = ocp_pkg::CFG_RST;
    c.dg_sel = 2'h1;
    put_cfg(c);
    ovl_req = 1'b1;
    cyc_n(ocp_pkg::DG_CYC_1 - 100);
    ovl_req = 1'b0;
    cyc_n(20);
    chk("stage", S_VOLT, 8'(stage));
    ovl_req = 1'b1;
    wait_ev(0, S_HIZ, ocp_pkg::DG_CYC_1, ocp_pkg::DG_CYC_1 + 10);
    recover(8'h01, S_HIZ);
  endtask

  task automatic t_limit();
    ilim_in = 8'h0a;
    ilim_wr = 1'b1;
    cyc_n(1);
    ilim_wr = 1'b0;
    cyc_n(1);
    chk("ilim", 8'h0a, ilim);
    c = ocp_pkg::CFG_RST;
    c.resp_limit = 1'b1;
    c.lim_sel = 3'h1;
    put_cfg(c);
    ovl_req = 1'b1;
    wait_ev(0, S_ILIM, DG0 + ocp_pkg::REACT_CYC_0, DG0 + ocp_pkg::REACT_CYC_0 + 15);
    wait_ev(0, S_VOLT, ocp_pkg::REACT_CYC_0 + 50, ocp_pkg::REACT_CYC_0 + 65);
    chk("alarm", 8'h00, 8'(alarm));
    wait_ev(0, S_ILIM, DG0 + ocp_pkg::REACT_CYC_0, DG0 + ocp_pkg::REACT_CYC_0 + 15);
    ovl_req = 1'b0;
    wait_ev(0, S_VOLT, ocp_pkg::REACT_CYC_0 + 50, ocp_pkg::REACT_CYC_0 + 65);
  endtask

  task automatic t_fail_short_cin();
    c = ocp_pkg::CFG_RST;
    c.resp_limit = 1'b1;
    c.react_sel = 2'h1;
    put_cfg(c);
    stiff = 1'b1;
    ovl_req = 1'b1;
    wait_ev(0, S_ILIM, DG0 + ocp_pkg::REACT_CYC_1, DG0 + ocp_pkg::REACT_CYC_1 + 15);
    wait_ev(0, S_HIZ, ocp_pkg::REACT_CYC_1, ocp_pkg::REACT_CYC_1 + 10);
    recover(8'h02, S_HIZ);
    short_req = 1'b1;
    wait_ev(0, S_HIZ, ocp_pkg::SC_CYC, ocp_pkg::SC_CYC + 10);
    recover(8'h04, S_HIZ);
    c = ocp_pkg::CFG_RST;
    c.cin_mode = 1'b1;
    c.cin_steps = 8'h01;
    put_cfg(c);
    cin_req = 1'b1;
    ovl_req = 1'b1;
    wait_ev(1, 8'h01, ocp_pkg::CIN_STEP_CYC, ocp_pkg::CIN_STEP_CYC + 10);
    chk("stage", S_VOLT, 8'(stage));
    recover(8'h08, S_VOLT);
  endtask

  // ==========================================================================
  // Sequence and hang guard.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 30000) begin
      n_fail++;
      report_and_stop();
    end
  end

  initial begin
    cyc_n(3);
    rstn = 1'b1;
    cyc_n(4);
    t_reset_thr();
    t_glitch_hiz();
    t_limit();
    t_fail_short_cin();
    report_and_stop();
  end
endmodule
`default_nettype wire
